// ### src/blce_core.sv
`timescale 1ns/100ps
module blce_core (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic [blce_pkg::INSTR_W-1:0] i_instr,
  input  wire logic [blce_pkg::DATA_W-1:0]  i_pins,
  output blce_pkg::blce_core_t              o_core,
  output logic                              o_discard
);
  import blce_pkg::*;

  blce_state_t              state_q;
  blce_state_t              state_d;
  logic [INSTR_W-1:0]       ir_q;
  logic [PC_W-1:0]          pc_q;
  logic [PC_W-1:0]          pc_d;
  logic [PC_W-1:0]          stack0_q;
  logic [PC_W-1:0]          stack1_q;
  logic [DATA_W-1:0]        w_q;
  logic [DATA_W-1:0]        status_q;
  logic [DATA_W-1:0]        port_q;
  logic [DATA_W-1:0]        pin_s1_q;
  logic [DATA_W-1:0]        pin_s2_q;
  logic [DATA_W-1:0]        mem_q [FILE_N];
  blce_bitop_t              bit_v;
  blce_byteop_t             byte_v;
  blce_litop_t              lit_v;
  logic                     is_run;
  logic                     do_bset;
  logic                     do_and_work_file_op;
  logic                     do_tclr;
  logic                     do_tset;
  logic                     do_clear_working_op;
  logic                     do_call;
  logic                     skip;
  logic [DATA_W-1:0]        fval;
  logic                     tbit;
  logic [DATA_W-1:0]        and_res;
  logic [DATA_W-1:0]        set_res;
  logic                     wr_en;
  logic [FADDR_W-1:0]       wr_addr;
  logic [DATA_W-1:0]        wr_data;
  logic [PC_W-1:0]          call_pc;

  // Pins come from outside the clock domain, so two flops precede any use.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_q <= PORT_RST;
      pin_s2_q <= PORT_RST;
    end else begin
      pin_s1_q <= i_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  // The same word is seen through three field layouts.
  assign bit_v  = blce_bitop_t'(ir_q);
  assign byte_v = blce_byteop_t'(ir_q);
  assign lit_v  = blce_litop_t'(ir_q);

  // Only the run state executes; fill and discard cycles act as no-ops.
  assign is_run   = (state_q == ST_RUN);
  assign do_bset  = is_run && (bit_v.op == OP_BIT_SET);
  assign do_and_work_file_op = is_run && (byte_v.op == OP_AND_WF);
  assign do_tclr  = is_run && (bit_v.op == OP_TEST_CLEAR);
  assign do_tset  = is_run && (bit_v.op == OP_TEST_SET);
  assign do_clear_working_op  = is_run && (ir_q == INSTR_CLEAR_W);
  assign do_call  = is_run && (lit_v.op == OP_CALL);

  // File read; the port address returns the synchronised pin levels so a
  // read-modify-write never copies a stale output latch back.
  always_comb begin
    if (bit_v.faddr == FILE_PORT) begin
      fval = pin_s2_q; // [RL12]
    end else if (bit_v.faddr == FILE_STATUS) begin
      fval = status_q;
    end else begin
      fval = mem_q[bit_v.faddr];
    end
  end

  // Operation results and the skip decision.
  assign tbit    = fval[bit_v.bsel];
  assign and_res = w_q & fval; // [RL2]
  assign set_res = fval | (BIT_ONE << bit_v.bsel); // [RL1]
  assign skip    = (do_tclr && !tbit) || (do_tset && tbit); // [RL4] [RL5]
  assign call_pc = {status_q[STATUS_PAGE_HI:STATUS_PAGE_LO], PC8_FILL,
                    lit_v.k}; // [RL9] [RL10]

  // File write port shared by bit set and AND with destination one.
  always_comb begin
    wr_en   = 1'b0;
    wr_addr = bit_v.faddr;
    wr_data = DATA_ZERO;
    if (do_bset) begin
      wr_en   = 1'b1;
      wr_data = set_res; // [RL1]
    end else if (do_and_work_file_op && byte_v.dest) begin
      wr_en   = 1'b1;
      wr_data = and_res; // [RL3]
    end
  end

  // Sequencer: a taken skip or a call spends one extra cycle discarding
  // the word that was prefetched behind it.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_FILL: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        if (skip || do_call) begin
          state_d = ST_DISCARD; // [RL6] [RL11]
        end else begin
          state_d = ST_RUN; // [RL13]
        end
      end
      ST_DISCARD: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_FILL;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_FILL;
    end else begin
      state_q <= state_d;
    end
  end

  // The fetched word is always latched; a discard cycle simply ignores it.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ir_q <= INSTR_NO_OP;
    end else begin
      ir_q <= i_instr;
    end
  end

  // Program counter: steps every cycle except when a call redirects it.
  always_comb begin
    if (do_call) begin
      pc_d = call_pc; // [RL9] [RL10]
    end else begin
      pc_d = pc_q + PC_STEP;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_q <= PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Two-level stack; pc_q already holds the call's address plus one.
  // An overflowing push silently loses the oldest entry.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stack0_q <= PC_RST;
      stack1_q <= PC_RST;
    end else if (do_call) begin
      stack0_q <= pc_q; // [RL8]
      stack1_q <= stack0_q;
    end
  end

  // Working register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_q <= W_RST;
    end else if (do_clear_working_op) begin
      w_q <= DATA_ZERO; // [RL7]
    end else if (do_and_work_file_op && !byte_v.dest) begin
      w_q <= and_res; // [RL3]
    end
  end

  // Status: a direct file write lands first, then the zero flag of the
  // AND or clear overrides its own bit. Other operations keep every flag.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_q <= STATUS_RST;
    end else begin
      if (wr_en && (wr_addr == FILE_STATUS)) begin
        status_q <= wr_data;
      end
      if (do_and_work_file_op) begin
        status_q[STATUS_Z] <= (and_res == DATA_ZERO); // [RL2]
      end else if (do_clear_working_op) begin
        status_q[STATUS_Z] <= 1'b1; // [RL7]
      end
    end
  end

  // Output latch of the I/O register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_q <= PORT_RST;
    end else if (wr_en && (wr_addr == FILE_PORT)) begin
      port_q <= wr_data; // [RL12]
    end
  end

  // General file registers; the status and port slots are never used here.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < FILE_N; i++) begin
        mem_q[i] <= FILE_RST;
      end
    end else if (wr_en && (wr_addr != FILE_STATUS) &&
                 (wr_addr != FILE_PORT)) begin
      mem_q[wr_addr] <= wr_data; // [RL1] [RL3]
    end
  end

  // Outputs are flop values wired straight out.
  assign o_core.pc     = pc_q;
  assign o_core.w      = w_q;
  assign o_core.status = status_q;
  assign o_core.tos    = stack0_q;
  assign o_core.port   = port_q;
  assign o_discard     = state_q[2];

  // Checks on the executed behaviour.
  bset_keeps_flags_a: assert property ( // [RL1]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_bset && (bit_v.faddr != FILE_STATUS) |=> $stable(status_q))
    else $error("Bit set changed the status register.");

  bset_mem_bit_a: assert property ( // [RL1]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_bset && (bit_v.faddr != FILE_STATUS) && (bit_v.faddr != FILE_PORT)
    |=> mem_q[$past(bit_v.faddr)][$past(bit_v.bsel)] == 1'b1)
    else $error("Bit set did not set the file bit.");

  and_zero_flag_a: assert property ( // [RL2]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_and_work_file_op |=> status_q[STATUS_Z] == ($past(and_res) == DATA_ZERO))
    else $error("AND with file set the wrong zero flag.");

  and_to_work_a: assert property ( // [RL3]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_and_work_file_op && !byte_v.dest |=> w_q == $past(w_q & fval))
    else $error("AND result missing from working register.");

  and_to_file_a: assert property ( // [RL3]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_and_work_file_op && byte_v.dest |=> $stable(w_q))
    else $error("AND to file changed the working register.");

  skip_clear_a: assert property ( // [RL4]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_tclr && !tbit |=> state_q == ST_DISCARD ##1 state_q == ST_RUN)
    else $error("Clear test did not skip for two cycles.");

  skip_set_a: assert property ( // [RL5]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_tset && tbit |=> state_q == ST_DISCARD ##1 state_q == ST_RUN)
    else $error("Set test did not skip for two cycles.");

  discard_idle_a: assert property ( // [RL6]
    @(posedge i_clk) disable iff (!i_rst_n)
    state_q == ST_DISCARD |=> $stable(w_q) && $stable(status_q)
    && pc_q == $past(pc_q) + PC_STEP)
    else $error("Discarded word had an effect.");

  test_flags_a: assert property ( // [RL4] [RL5]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_tclr || do_tset |=> $stable(status_q)
    ##1 ($past(state_q) != ST_DISCARD || $stable(status_q)))
    else $error("Bit test changed the status register.");

  clear_work_a: assert property ( // [RL7]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_clear_working_op |=> w_q == DATA_ZERO && status_q[STATUS_Z])
    else $error("Clear working left a wrong value or flag.");

  call_push_a: assert property ( // [RL8]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_call |=> stack0_q == $past(pc_q) && stack1_q == $past(stack0_q))
    else $error("Call pushed a wrong return address.");

  call_target_a: assert property ( // [RL9] [RL10]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_call |=> pc_q == {$past(status_q[STATUS_PAGE_HI:STATUS_PAGE_LO]),
                         PC8_FILL, $past(lit_v.k)})
    else $error("Call loaded a wrong program counter.");

  call_two_cycle_a: assert property ( // [RL11]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_call |=> state_q == ST_DISCARD && $stable(status_q)
    ##1 state_q == ST_RUN && $stable(status_q))
    else $error("Call did not take two cycles cleanly.");

  port_from_pins_a: assert property ( // [RL12]
    @(posedge i_clk) disable iff (!i_rst_n)
    do_bset && (bit_v.faddr == FILE_PORT)
    |=> port_q == ($past(pin_s2_q) | (BIT_ONE << $past(bit_v.bsel))))
    else $error("Port rewrite did not start from pin levels.");

  no_skip_a: assert property ( // [RL13]
    @(posedge i_clk) disable iff (!i_rst_n)
    (do_tclr && tbit) || (do_tset && !tbit) |=> state_q == ST_RUN)
    else $error("Untaken bit test stalled the sequence.");

endmodule // blce_core

// ### src/blce_pkg.sv
// Contract
// [RL1] Bit set forces bit b of file register f to one; flags untouched.
// [RL2] AND with file ANDs working register and file f; only zero flag updates.
// [RL3] AND destination 0 writes working register, 1 writes file f back.
// [RL4] Test skip if clear skips next instruction when bit b reads zero.
// [RL5] Test skip if set skips next instruction when bit b reads one.
// [RL6] Taken skip discards the prefetched word, runs a no-op; two cycles.
// [RL7] Clear working loads zero into working register and sets zero flag.
// [RL8] Call first pushes return address, program counter plus one, on stack.
// [RL9] Call loads its 8-bit immediate target into program counter bits 7:0.
// [RL10] Call copies status bits 6:5 into counter bits 10:9, clears bit 8.
// [RL11] Call takes two instruction cycles and leaves all flags unchanged.
// [RL12] Read-modify-write of the I/O register reads pin levels, not latch.
// [RL13] Untaken bit test lets the next instruction run; one cycle.
package blce_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned INSTR_W = 12;
  localparam int unsigned PC_W    = 11;
  localparam int unsigned FADDR_W = 5;
  localparam int unsigned BSEL_W  = 3;
  localparam int unsigned FILE_N  = 32;
  localparam int unsigned LIT_W   = 8;

  // Major opcode fields of the handled instructions.
  localparam logic [3:0]         OP_BIT_SET    = 4'h5;
  localparam logic [3:0]         OP_TEST_CLEAR = 4'h6;
  localparam logic [3:0]         OP_TEST_SET   = 4'h7;
  localparam logic [3:0]         OP_CALL       = 4'h9;
  localparam logic [5:0]         OP_AND_WF     = 6'h05;
  localparam logic [INSTR_W-1:0] INSTR_CLEAR_W = 12'h040;
  localparam logic [INSTR_W-1:0] INSTR_NO_OP   = 12'h000;

  // File map positions of the special registers.
  localparam logic [FADDR_W-1:0] FILE_STATUS = 5'h03;
  localparam logic [FADDR_W-1:0] FILE_PORT   = 5'h06;

  // Status register field positions.
  localparam int unsigned STATUS_Z       = 2;
  localparam int unsigned STATUS_PAGE_HI = 6;
  localparam int unsigned STATUS_PAGE_LO = 5;

  // Reset values and fixed fill values.
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
  localparam logic [DATA_W-1:0] W_RST      = 8'h00;
  localparam logic [DATA_W-1:0] FILE_RST   = 8'h00;
  localparam logic [DATA_W-1:0] PORT_RST   = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0] BIT_ONE    = 8'h01;
  localparam logic [PC_W-1:0]   PC_RST     = 11'h000;
  localparam logic [PC_W-1:0]   PC_STEP    = 11'h001;
  localparam logic              PC8_FILL   = 1'b0;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_FILL    = 3'b001,
    ST_RUN     = 3'b010,
    ST_DISCARD = 3'b100
  } blce_state_t;

  // Views of one instruction word.
  typedef struct packed {
    logic [3:0]         op;
    logic [BSEL_W-1:0]  bsel;
    logic [FADDR_W-1:0] faddr;
  } blce_bitop_t;

  typedef struct packed {
    logic [5:0]         op;
    logic               dest;
    logic [FADDR_W-1:0] faddr;
  } blce_byteop_t;

  typedef struct packed {
    logic [3:0]       op;
    logic [LIT_W-1:0] k;
  } blce_litop_t;

  // Architectural state shown to the outside.
  typedef struct packed {
    logic [PC_W-1:0]   pc;
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] status;
    logic [PC_W-1:0]   tos;
    logic [DATA_W-1:0] port;
  } blce_core_t;

endpackage

// ### tb/blce_core_tb.sv
`timescale 1ns/100ps
module blce_core_tb;
  import blce_pkg::*;

  logic               i_clk;
  logic               i_rst_n;
  logic [INSTR_W-1:0] i_instr;
  logic [DATA_W-1:0]  i_pins;
  blce_core_t         o_core;
  logic               o_discard;
  logic [INSTR_W-1:0] mem [0:2047];
  int                 err_total;
  int                 n_compared;

  blce_core DUT (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_instr   (i_instr),
    .i_pins    (i_pins),
    .o_core    (o_core),
    .o_discard (o_discard)
  );

  // Free-running core clock at 10 MHz.
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // Program memory; updated off the sampling edge so the fetch is stable.
  always @(negedge i_clk) begin
    i_instr <= mem[o_core.pc];
  end

  function automatic logic [INSTR_W-1:0] bitw(input logic [3:0] op,
                                               input int b, input int f);
    return {op, 3'(b), 5'(f)};
  endfunction

  function automatic logic [INSTR_W-1:0] andw(input logic d, input int f);
    return {OP_AND_WF, d, 5'(f)};
  endfunction

  // Expected file value once bit b has been forced to one.
  function automatic logic [7:0] set_bit(input logic [7:0] v, input int b);
    return v | 8'(8'h01 << b);
  endfunction

  // Expected call destination: page bits on top, bit 8 cleared, then k.
  function automatic logic [10:0] call_dest(input logic [1:0] pg,
                                            input logic [7:0] k);
    return {pg, 1'b0, k};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic end_sim();
    $display("Checks made %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Fills with no-ops so that stray fetches have no side effects.
  task automatic clear_mem();
    foreach (mem[i]) mem[i] = INSTR_NO_OP;
  endtask

  // Reset for two cycles; release lands on a falling edge, away from the
  // rising edge, and pins settle long before the first port access.
  task automatic start(input logic [7:0] p);
    @(negedge i_clk);
    i_rst_n = 1'b0;
    i_pins  = p;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // Clear, bit set, and the two destinations of the AND operation.
  task automatic scen_basic();
    int         b;
    logic [7:0] p;
    b = $urandom % 8;
    p = 8'($urandom);
    clear_mem();
    mem[0] = INSTR_CLEAR_W;
    mem[1] = bitw(OP_BIT_SET, 5, 3);
    mem[2] = bitw(OP_BIT_SET, b, 6);
    mem[3] = andw(1'b0, 6);
    mem[4] = andw(1'b1, 6);
    mem[5] = andw(1'b1, 3);
    start(p);
    tick(2);
    chk(o_core.w, 32'h00);
    chk(o_core.status, 32'h04);
    tick(1);
    chk(o_core.status, 32'h24);
    tick(1);
    chk(o_core.port, set_bit(p, b));
    chk(o_core.status, 32'h24);
    tick(1);
    chk(o_core.w, 32'h00);
    chk(o_core.port, set_bit(p, b));
    chk(o_core.status, 32'h24);
    tick(1);
    chk(o_core.port, 32'h00);
    tick(1);
    chk(o_core.status, 32'h04);
  endtask

  // Call from address 2 with random page bits; the word after the call
  // would set port bit 1 and must be dropped.
  task automatic scen_call();
    logic [1:0]  pg;
    logic [7:0]  k;
    logic [10:0] tgt;
    pg = 2'($urandom);
    k  = 8'(8 + $urandom % 248);
    tgt = call_dest(pg, k);
    clear_mem();
    mem[0] = pg[1] ? bitw(OP_BIT_SET, 6, 3) : INSTR_NO_OP;
    mem[1] = pg[0] ? bitw(OP_BIT_SET, 5, 3) : INSTR_NO_OP;
    mem[2] = {OP_CALL, k};
    mem[3] = bitw(OP_BIT_SET, 1, 6);
    mem[tgt] = bitw(OP_BIT_SET, 0, 6);
    start(8'h00);
    tick(4);
    chk(o_core.pc[7:0], k);
    chk(o_core.pc[10:8], {pg, 1'b0});
    chk(o_core.tos, 32'h003);
    chk(o_discard, 32'h1);
    chk(o_core.status, {pg, 5'h00});
    tick(1);
    chk(o_discard, 32'h0);
    chk(o_core.port, 32'h00);
    chk(o_core.pc, tgt + 11'h001);
    tick(1);
    chk(o_core.port, 32'h01);
  endtask

  // Both bit tests against a set and a clear bit; the corner cases use the
  // top bit of the last file register.
  task automatic scen_skip(input int i);
    logic [3:0] op;
    logic       val;
    logic       taken;
    int         b;
    int         f;
    op    = i[0] ? OP_TEST_SET : OP_TEST_CLEAR;
    val   = i[1];
    taken = (i[0] == val);
    b = (i >= 4) ? 7 : $urandom % 8;
    f = (i >= 4) ? 31 : 7 + $urandom % 25;
    clear_mem();
    mem[0] = val ? bitw(OP_BIT_SET, b, f) : INSTR_NO_OP;
    mem[1] = bitw(op, b, f);
    mem[2] = bitw(OP_BIT_SET, 2, 6);
    mem[3] = bitw(OP_BIT_SET, 3, 6);
    start(8'h00);
    tick(3);
    chk(o_discard, taken);
    chk(o_core.status, 32'h00);
    tick(1);
    chk(o_core.port, taken ? 32'h00 : 32'h04);
    chk(o_core.pc, 32'h004);
    chk(o_discard, 32'h0);
    tick(1);
    chk(o_core.port, 32'h08);
  endtask

  // A hang is cut off far beyond the roughly 130 cycles the run needs.
  initial begin
    #100000;
    err_total++;
    $display("[ERR] t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    i_rst_n    = 1'b0;
    i_instr    = INSTR_NO_OP;
    i_pins     = 8'h00;
    err_total  = 0;
    n_compared = 0;
    void'($urandom(32'h5ECE));
    repeat (3) scen_basic();
    repeat (4) scen_call();
    for (int i = 0; i < 8; i++) begin
      scen_skip(i);
    end
    end_sim();
  end
endmodule // blce_core_tb
